/* iosm_pkg.sv */
// Shared constants, register map and helper functions of the I/O signal mapping block.
package iosm_pkg;

    // -------------------------------------------------------------------------
    // Clock and timing
    // -------------------------------------------------------------------------
    localparam int CLK_HZ      = 20_000_000;
    localparam int TICK_MS     = 1;
    localparam int TICK_CYC    = CLK_HZ / 1000 * TICK_MS;
    localparam int ONESHOT_US  = 250;
    localparam int ONESHOT_CYC = int'((64'(ONESHOT_US) * 64'(CLK_HZ)) / 64'd1000000);
    localparam int DEAD_MAX_MS = 250;

    // -------------------------------------------------------------------------
    // Sizes
    // -------------------------------------------------------------------------
    localparam int N_DIN  = 10;
    localparam int N_VIN  = 4;
    localparam int N_DOUT = 6;
    localparam int N_USR  = 2;
    localparam int SIG_W  = 32;
    localparam int SEL_W  = 5;
    localparam int MS_W   = 8;
    localparam int CNT_W  = 16;
    localparam int ADDR_W = 8;

    // -------------------------------------------------------------------------
    // Register offsets (byte addresses)
    // -------------------------------------------------------------------------
    localparam logic [ADDR_W-1:0] REG_STATUS    = 8'h00;
    localparam logic [ADDR_W-1:0] REG_FUNC      = 8'h04;
    localparam logic [ADDR_W-1:0] REG_DIN_BASE  = 8'h40;
    localparam logic [ADDR_W-1:0] REG_VIN_BASE  = 8'h80;
    localparam logic [ADDR_W-1:0] REG_DOUT_BASE = 8'hC0;
    localparam logic [ADDR_W-1:0] REG_USR_BASE  = 8'hE0;

    // -------------------------------------------------------------------------
    // Field positions and reset values
    // -------------------------------------------------------------------------
    localparam int F_SEL_LSB  = 0;
    localparam int F_SEL2_LSB = 8;
    localparam int F_INV      = 16;
    localparam int F_AUX      = 17;
    localparam int F_OR       = 18;
    localparam int F_MS_LSB   = 24;
    localparam int ST_VIN_LSB = 10;
    localparam int ST_DOUT_LSB = 14;
    localparam int ST_USR_LSB = 20;
    localparam logic [31:0] CFG_RST = 32'h0000_0000;

    // -------------------------------------------------------------------------
    // Helpers
    // -------------------------------------------------------------------------
    // Code zero means "not used": it asserts nothing.
    function automatic logic [SIG_W-1:0] onehot(input logic [SEL_W-1:0] sel);
        onehot = (sel == '0) ? '0 : (SIG_W'(1) << sel);
    endfunction

    // Code zero selects a constant OFF source.
    function automatic logic pick(input logic [SIG_W-1:0] vec, input logic [SEL_W-1:0] sel);
        pick = (sel == '0) ? 1'b0 : vec[sel];
    endfunction

endpackage

/* iosm_chan_if.sv */
// Channel interface between the mapping top and its conditioning stages.
`timescale 1ns/1ps
interface iosm_chan_if;
    logic              tick;
    logic              raw;
    logic              raw2;
    logic              inv;
    logic              inv2;
    logic              aux;
    logic [7:0]        ms;
    logic              state;

    modport ctrl (output tick, raw, raw2, inv, inv2, aux, ms, input state);
    modport cond (input tick, raw, raw2, inv, inv2, aux, ms, output state);
endinterface

/* iosm_in_cond.sv */
// Input conditioning: inversion, ON dead-time filter and one-shot pulse.
`timescale 1ns/1ps
module iosm_in_cond #(
    parameter int ONESHOT_CYCLES = iosm_pkg::ONESHOT_CYC
) (
    // Clock and reset
    input  wire logic clk_sys_i,
    input  wire logic arst_n_i,
    // Channel
    iosm_chan_if.cond ch
);
    import iosm_pkg::*;

    logic             lvl;
    logic             filt;
    logic             rise;
    logic [MS_W-1:0]  dead_q,  dead_d;
    logic [CNT_W-1:0] os_q,    os_d;
    logic             filt_q,  filt_d;
    logic             st_q,    st_d;

    always_comb begin
        lvl  = ch.raw ^ ch.inv;
        filt = lvl && (dead_q >= ch.ms);
        rise = filt && !filt_q;
        dead_d = dead_q;
        if (!lvl) begin
            dead_d = '0;
        end else if (ch.tick && dead_q < ch.ms) begin
            dead_d = dead_q + MS_W'(1);
        end
        filt_d = filt;
        if (rise) begin
            os_d = CNT_W'(ONESHOT_CYCLES);
        end else if (os_q != '0) begin
            os_d = os_q - CNT_W'(1);
        end else begin
            os_d = '0;
        end
        st_d = ch.aux ? (os_d != '0) : filt;
    end

    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            dead_q <= '0;
            os_q   <= '0;
            filt_q <= 1'b0;
            st_q   <= 1'b0;
        end else begin
            dead_q <= dead_d;
            os_q   <= os_d;
            filt_q <= filt_d;
            st_q   <= st_d;
        end
    end

    assign ch.state = st_q;
endmodule // iosm_in_cond

/* iosm_out_cond.sv */
// Direct output conditioning: inversion, OFF delay and composite AND/OR.
`timescale 1ns/1ps
module iosm_out_cond (
    // Clock and reset
    input  wire logic clk_sys_i,
    input  wire logic arst_n_i,
    // Channel
    iosm_chan_if.cond ch
);
    import iosm_pkg::*;

    logic            lvl;
    logic            comp;
    logic [MS_W-1:0] off_q,  off_d;
    logic            norm_q, norm_d;
    logic            st_q,   st_d;

    always_comb begin
        lvl   = ch.raw ^ ch.inv;
        off_d = off_q;
        if (lvl) begin
            off_d = '0;
        end else if (ch.tick && off_q < ch.ms) begin
            off_d = off_q + MS_W'(1);
        end
        norm_d = lvl || (norm_q && off_q < ch.ms);
        comp   = ch.raw2 ^ ch.inv2;
        st_d   = ch.aux ? (norm_q || comp) : (norm_q && comp);
    end

    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            off_q  <= '0;
            norm_q <= 1'b0;
            st_q   <= 1'b0;
        end else begin
            off_q  <= off_d;
            norm_q <= norm_d;
            st_q   <= st_d;
        end
    end

    assign ch.state = st_q;
endmodule // iosm_out_cond

/* iosm_top.sv */
// Top of the I/O signal mapping block with its Avalon-MM register slave.
//
// Notes on behaviour
// - Each direct input asserts the input function chosen for it.
// - Optional per-input inversion swaps ON and OFF before the function.
// - An input turns ON only after staying asserted past its dead-time.
// - With one-shot enabled, the function drops OFF 250 us after turning ON.
// - A direct input that is ON also asserts its composite function.
// - Four virtual inputs run alongside the direct inputs without wiring.
// - A virtual input is triggered by a selected internal output signal.
// - Each direct output carries the internal signal selected for it.
// - Optional per-output inversion swaps the selected signal's sense.
// - A direct output drops only after its source is off past the delay.
// - A direct output is the AND or OR of normal and second signal.
// - Optional composite inversion swaps the second signal before combining.
// - Two internal user outputs, each fed by sources A and B.
// - Sources A and B each have their own inversion.
// - A user output is the AND or OR of its sources A and B.
// - Ten direct inputs; dead-time 0 to 250 ms, default zero.
//
// Chosen here: the Avalon-MM register port and the placing of the registers.
`timescale 1ns/1ps
module iosm_top #(
    parameter int MS_CYCLES      = iosm_pkg::TICK_CYC,
    parameter int ONESHOT_CYCLES = iosm_pkg::ONESHOT_CYC
) (
    // Clock and reset
    input  wire logic                          clk_sys_i,
    input  wire logic                          arst_n_i,
    // Avalon-MM slave
    input  wire logic [iosm_pkg::ADDR_W-1:0]   avs_address_i,
    input  wire logic                          avs_read_i,
    input  wire logic                          avs_write_i,
    input  wire logic [31:0]                   avs_writedata_i,
    input  wire logic [3:0]                    avs_byteenable_i,
    output logic      [31:0]                   avs_readdata_o,
    output logic                               avs_waitrequest_o,
    // Direct input pins and internal output signals
    input  wire logic [iosm_pkg::N_DIN-1:0]    din_i,
    input  wire logic [iosm_pkg::SIG_W-1:0]    out_sig_i,
    // Mapped results
    output logic      [iosm_pkg::SIG_W-1:0]    func_o,
    output logic      [iosm_pkg::N_DOUT-1:0]   dout_o,
    output logic      [iosm_pkg::N_USR-1:0]    user_output_o
);
    import iosm_pkg::*;

    // -------------------------------------------------------------------------
    // Helpers
    // -------------------------------------------------------------------------
    // Merges write data into a register under the byte enables.
    function automatic logic [31:0] be_merge(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0]  be);
        logic [31:0] r;
        r = old_v;
        for (int b = 0; b < 4; b++) begin
            if (be[b]) begin
                r[b*8 +: 8] = new_v[b*8 +: 8];
            end
        end
        be_merge = r;
    endfunction

    // Limits the millisecond field of a configuration word.
    function automatic logic [31:0] clamp_ms(input logic [31:0] v);
        logic [31:0] r;
        r = v;
        if (v[F_MS_LSB +: MS_W] > MS_W'(DEAD_MAX_MS)) begin
            r[F_MS_LSB +: MS_W] = MS_W'(DEAD_MAX_MS);
        end
        clamp_ms = r;
    endfunction

    function automatic logic [SEL_W-1:0] sel_f(input logic [31:0] v);
        sel_f = v[F_SEL_LSB +: SEL_W];
    endfunction

    function automatic logic [SEL_W-1:0] sel2_f(input logic [31:0] v);
        sel2_f = v[F_SEL2_LSB +: SEL_W];
    endfunction

    // -------------------------------------------------------------------------
    // Declarations
    // -------------------------------------------------------------------------
    logic [31:0]      din_cfg_q  [N_DIN];
    logic [31:0]      din_cfg_d  [N_DIN];
    logic [31:0]      vin_cfg_q  [N_VIN];
    logic [31:0]      vin_cfg_d  [N_VIN];
    logic [31:0]      dout_cfg_q [N_DOUT];
    logic [31:0]      dout_cfg_d [N_DOUT];
    logic [31:0]      usr_cfg_q  [N_USR];
    logic [31:0]      usr_cfg_d  [N_USR];
    logic             wait_q,  wait_d;
    logic [31:0]      rdata_q, rdata_d;
    logic [CNT_W-1:0] pre_q,   pre_d;
    logic             tick_q,  tick_d;
    logic [SIG_W-1:0] func_q,  func_d;
    logic [N_DOUT-1:0] dout_q, dout_d;
    logic [N_USR-1:0] usr_q,   usr_d;
    logic [N_DIN-1:0] din_st;
    logic [N_VIN-1:0] vin_st;
    logic [N_DOUT-1:0] dout_st;
    logic             wr_go;

    // -------------------------------------------------------------------------
    // Millisecond tick
    // -------------------------------------------------------------------------
    always_comb begin
        tick_d = 1'b0;
        pre_d  = pre_q + CNT_W'(1);
        if (pre_q >= CNT_W'(MS_CYCLES - 1)) begin
            pre_d  = '0;
            tick_d = 1'b1;
        end
    end

    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            pre_q  <= '0;
            tick_q <= 1'b0;
        end else begin
            pre_q  <= pre_d;
            tick_q <= tick_d;
        end
    end

    // -------------------------------------------------------------------------
    // Direct inputs
    // -------------------------------------------------------------------------
    for (genvar i = 0; i < N_DIN; i++) begin : g_din
        iosm_chan_if u_ch ();
        assign u_ch.tick = tick_q;
        assign u_ch.raw  = din_i[i];
        assign u_ch.raw2 = 1'b0;
        assign u_ch.inv  = din_cfg_q[i][F_INV];
        assign u_ch.inv2 = 1'b0;
        assign u_ch.aux  = din_cfg_q[i][F_AUX];
        assign u_ch.ms   = din_cfg_q[i][F_MS_LSB +: MS_W];
        assign din_st[i] = u_ch.state;
        iosm_in_cond #(
            .ONESHOT_CYCLES (ONESHOT_CYCLES)
        ) u_cond (
            .clk_sys_i (clk_sys_i),
            .arst_n_i  (arst_n_i),
            .ch        (u_ch)
        );
    end

    // -------------------------------------------------------------------------
    // Virtual inputs
    // -------------------------------------------------------------------------
    for (genvar j = 0; j < N_VIN; j++) begin : g_vin
        iosm_chan_if u_ch ();
        assign u_ch.tick = tick_q;
        assign u_ch.raw  = pick(out_sig_i, sel2_f(vin_cfg_q[j]));
        assign u_ch.raw2 = 1'b0;
        assign u_ch.inv  = vin_cfg_q[j][F_INV];
        assign u_ch.inv2 = 1'b0;
        assign u_ch.aux  = vin_cfg_q[j][F_AUX];
        assign u_ch.ms   = vin_cfg_q[j][F_MS_LSB +: MS_W];
        assign vin_st[j] = u_ch.state;
        iosm_in_cond #(
            .ONESHOT_CYCLES (ONESHOT_CYCLES)
        ) u_cond (
            .clk_sys_i (clk_sys_i),
            .arst_n_i  (arst_n_i),
            .ch        (u_ch)
        );
    end

    // -------------------------------------------------------------------------
    // Direct outputs
    // -------------------------------------------------------------------------
    for (genvar k = 0; k < N_DOUT; k++) begin : g_dout
        iosm_chan_if u_ch ();
        assign u_ch.tick  = tick_q;
        assign u_ch.raw   = pick(out_sig_i, sel_f(dout_cfg_q[k]));
        assign u_ch.raw2  = pick(out_sig_i, sel2_f(dout_cfg_q[k]));
        assign u_ch.inv   = dout_cfg_q[k][F_INV];
        assign u_ch.inv2  = dout_cfg_q[k][F_AUX];
        assign u_ch.aux   = dout_cfg_q[k][F_OR];
        assign u_ch.ms    = dout_cfg_q[k][F_MS_LSB +: MS_W];
        assign dout_st[k] = u_ch.state;
        iosm_out_cond u_cond (
            .clk_sys_i (clk_sys_i),
            .arst_n_i  (arst_n_i),
            .ch        (u_ch)
        );
    end

    // -------------------------------------------------------------------------
    // Function map, user outputs and output registers
    // -------------------------------------------------------------------------
    always_comb begin
        logic a;
        logic b;
        a      = 1'b0;
        b      = 1'b0;
        func_d = '0;
        for (int i = 0; i < N_DIN; i++) begin
            if (din_st[i]) begin
                func_d = func_d | onehot(sel_f(din_cfg_q[i]));
                func_d = func_d | onehot(sel2_f(din_cfg_q[i]));
            end
        end
        for (int j = 0; j < N_VIN; j++) begin
            if (vin_st[j]) begin
                func_d = func_d | onehot(sel_f(vin_cfg_q[j]));
            end
        end
        usr_d = '0;
        for (int u = 0; u < N_USR; u++) begin
            a = pick(out_sig_i, sel_f(usr_cfg_q[u])) ^ usr_cfg_q[u][F_INV];
            b = pick(out_sig_i, sel2_f(usr_cfg_q[u])) ^ usr_cfg_q[u][F_AUX];
            usr_d[u] = usr_cfg_q[u][F_OR] ? (a | b) : (a & b);
        end
        dout_d = dout_st;
    end

    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            func_q <= '0;
            dout_q <= '0;
            usr_q  <= '0;
        end else begin
            func_q <= func_d;
            dout_q <= dout_d;
            usr_q  <= usr_d;
        end
    end

    // -------------------------------------------------------------------------
    // Avalon-MM slave
    // -------------------------------------------------------------------------
    // A request is held in wait for one cycle; the next edge completes it.
    assign wr_go = avs_write_i && !wait_q;

    always_comb begin
        wait_d  = !((avs_read_i || avs_write_i) && wait_q);
        rdata_d = rdata_q;
        if (avs_read_i && wait_q) begin
            rdata_d = '0;
            if (avs_address_i == REG_STATUS) begin
                rdata_d[N_DIN-1:0]                 = din_st;
                rdata_d[ST_VIN_LSB +: N_VIN]       = vin_st;
                rdata_d[ST_DOUT_LSB +: N_DOUT]     = dout_q;
                rdata_d[ST_USR_LSB +: N_USR]       = usr_q;
            end else if (avs_address_i == REG_FUNC) begin
                rdata_d = func_q;
            end
            for (int i = 0; i < N_DIN; i++) begin
                if (avs_address_i == REG_DIN_BASE + ADDR_W'(4 * i)) begin
                    rdata_d = din_cfg_q[i];
                end
            end
            for (int j = 0; j < N_VIN; j++) begin
                if (avs_address_i == REG_VIN_BASE + ADDR_W'(4 * j)) begin
                    rdata_d = vin_cfg_q[j];
                end
            end
            for (int k = 0; k < N_DOUT; k++) begin
                if (avs_address_i == REG_DOUT_BASE + ADDR_W'(4 * k)) begin
                    rdata_d = dout_cfg_q[k];
                end
            end
            for (int u = 0; u < N_USR; u++) begin
                if (avs_address_i == REG_USR_BASE + ADDR_W'(4 * u)) begin
                    rdata_d = usr_cfg_q[u];
                end
            end
        end
    end

    always_comb begin
        din_cfg_d  = din_cfg_q;
        vin_cfg_d  = vin_cfg_q;
        dout_cfg_d = dout_cfg_q;
        usr_cfg_d  = usr_cfg_q;
        if (wr_go) begin
            for (int i = 0; i < N_DIN; i++) begin
                if (avs_address_i == REG_DIN_BASE + ADDR_W'(4 * i)) begin
                    din_cfg_d[i] = clamp_ms(be_merge(din_cfg_q[i], avs_writedata_i,
                                                     avs_byteenable_i));
                end
            end
            for (int j = 0; j < N_VIN; j++) begin
                if (avs_address_i == REG_VIN_BASE + ADDR_W'(4 * j)) begin
                    vin_cfg_d[j] = clamp_ms(be_merge(vin_cfg_q[j], avs_writedata_i,
                                                     avs_byteenable_i));
                end
            end
            for (int k = 0; k < N_DOUT; k++) begin
                if (avs_address_i == REG_DOUT_BASE + ADDR_W'(4 * k)) begin
                    dout_cfg_d[k] = clamp_ms(be_merge(dout_cfg_q[k], avs_writedata_i,
                                                      avs_byteenable_i));
                end
            end
            for (int u = 0; u < N_USR; u++) begin
                if (avs_address_i == REG_USR_BASE + ADDR_W'(4 * u)) begin
                    usr_cfg_d[u] = be_merge(usr_cfg_q[u], avs_writedata_i,
                                            avs_byteenable_i);
                end
            end
        end
    end

    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            wait_q  <= 1'b1;
            rdata_q <= '0;
            for (int i = 0; i < N_DIN; i++) begin
                din_cfg_q[i] <= CFG_RST;
            end
            for (int j = 0; j < N_VIN; j++) begin
                vin_cfg_q[j] <= CFG_RST;
            end
            for (int k = 0; k < N_DOUT; k++) begin
                dout_cfg_q[k] <= CFG_RST;
            end
            for (int u = 0; u < N_USR; u++) begin
                usr_cfg_q[u] <= CFG_RST;
            end
        end else begin
            wait_q     <= wait_d;
            rdata_q    <= rdata_d;
            din_cfg_q  <= din_cfg_d;
            vin_cfg_q  <= vin_cfg_d;
            dout_cfg_q <= dout_cfg_d;
            usr_cfg_q  <= usr_cfg_d;
        end
    end

    // -------------------------------------------------------------------------
    // Outputs
    // -------------------------------------------------------------------------
    assign avs_readdata_o    = rdata_q;
    assign avs_waitrequest_o = wait_q;
    assign func_o            = func_q;
    assign dout_o            = dout_q;
    assign user_output_o     = usr_q;

endmodule // iosm_top

/* iosm_checker.sv */
// Concurrent checks on the ports of the I/O signal mapping top.
`timescale 1ns/1ps
module iosm_checker (
    // Clock and reset
    input wire logic        clk_sys_i,
    input wire logic        arst_n_i,
    // Watched ports
    input wire logic [7:0]  avs_address_i,
    input wire logic        avs_read_i,
    input wire logic        avs_write_i,
    input wire logic [31:0] avs_readdata_o,
    input wire logic        avs_waitrequest_o,
    input wire logic [31:0] func_o,
    input wire logic [5:0]  dout_o,
    input wire logic [1:0]  user_output_o
);
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (!arst_n_i);
    wire logic rd_done = avs_read_i && !avs_waitrequest_o;
    wire logic req     = avs_read_i || avs_write_i;

    chk_wait_pulse: assert property ($fell(avs_waitrequest_o) |=> avs_waitrequest_o)
        else $error("waitrequest low longer than one cycle");
    chk_req_answer: assert property (req && avs_waitrequest_o |=> !avs_waitrequest_o)
        else $error("request not answered next cycle");
    chk_idle_wait: assert property (!req && avs_waitrequest_o |=> avs_waitrequest_o)
        else $error("waitrequest dropped without request");
    chk_func_read: assert property (
        rd_done && avs_address_i == 8'h04 |-> avs_readdata_o == $past(func_o))
        else $error("function word read differs from func_o");
    chk_stat_read: assert property (
        rd_done && avs_address_i == 8'h00 |->
        avs_readdata_o[21:14] == {$past(user_output_o), $past(dout_o)})
        else $error("status read differs from outputs");
    chk_unmapped_zero: assert property (
        rd_done && avs_address_i inside {[8'h08:8'h3C]} |-> avs_readdata_o == 32'h0)
        else $error("unmapped read not zero");
    chk_rdata_hold: assert property (!(avs_read_i && avs_waitrequest_o) |=> $stable(avs_readdata_o))
        else $error("read data changed without read");
    chk_code_zero: assert property (func_o[0] == 1'b0)
        else $error("function code zero asserted");
    chk_reset_clear: assert property (
        $rose(arst_n_i) |-> {func_o, dout_o, user_output_o} == 40'h0)
        else $error("outputs not clear after reset");

    cov_func_read: cover property (rd_done && avs_address_i == 8'h04);
    cov_dout_on: cover property ($rose(dout_o[5]));
    cov_user_on: cover property ($rose(user_output_o[1]));
endmodule // iosm_checker

bind iosm_top iosm_checker i_iosm_checker (.clk_sys_i, .arst_n_i, .avs_address_i, .avs_read_i,
    .avs_write_i, .avs_readdata_o, .avs_waitrequest_o, .func_o, .dout_o, .user_output_o);

/* iosm_host_model.sv */
// Host controller model that drives the direct input pins.
`timescale 1ns/1ps
module iosm_host_model (
    // Clock
    input  wire logic       clk_sys_i,
    // Asked levels and driven pins
    input  wire logic [9:0] want_i,
    output logic      [9:0] din_o
);
    // Pins change just after an edge, as from a real cable driver.
    initial din_o = 10'h000;
    always @(posedge clk_sys_i) din_o <= want_i;
endmodule // iosm_host_model

/* io_signal_mapping_tb.sv */
// Self-checking bench of the I/O signal mapping top.
`timescale 1ns/1ps
module io_signal_mapping_tb;
    import iosm_pkg::*;
    logic        clk = 1'b0;
    logic        arst_n = 1'b0;
    logic [7:0]  addr = 8'h00;
    logic        rd = 1'b0;
    logic        wr = 1'b0;
    logic [31:0] wdata = 32'h0;
    logic [31:0] rdata, rq, func, sig = 32'h0;
    logic        wait_o;
    logic [9:0]  want = 10'h000, din;
    logic [5:0]  dout;
    logic [1:0]  usr;
    int          mismatches = 0, tests_run = 0, cyc = 0;
    logic        e;

    always #25 clk = ~clk;

    iosm_host_model i_iosm_host_model (.clk_sys_i(clk), .want_i(want), .din_o(din));
    iosm_top #(.MS_CYCLES(20), .ONESHOT_CYCLES(8)) i_iosm_top (.clk_sys_i(clk),
        .arst_n_i(arst_n), .avs_address_i(addr), .avs_read_i(rd), .avs_write_i(wr),
        .avs_writedata_i(wdata), .avs_byteenable_i(4'hF), .avs_readdata_o(rdata),
        .avs_waitrequest_o(wait_o), .din_i(din), .out_sig_i(sig), .func_o(func),
        .dout_o(dout), .user_output_o(usr));

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD %s exp %h got %h", what, exp, got);
        end
    endtask

    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        addr <= a;
        wr <= w;
        rd <= !w;
        wdata <= d;
        do @(posedge clk); while (wait_o !== 1'b0);
        rq = rdata;
        rd <= 1'b0;
        wr <= 1'b0;
        @(posedge clk);
    endtask

    task automatic t_defaults();
        bus(0, 8'h40, 0); chk("din0 cfg", 0, rq);
        bus(0, 8'h08, 0); chk("unmapped", 0, rq);
        bus(0, 8'h04, 0); chk("func", 0, rq);
        $display("defaults done");
    endtask

    task automatic t_din();
        bus(1, 8'h64, 32'h0000_0703);
        want[9] <= 1'b1;
        repeat (6) @(posedge clk);
        chk("din on", 32'h88, func);
        bus(1, 8'h64, 32'h0001_0703);
        repeat (6) @(posedge clk);
        chk("inv high", 0, func);
        want[9] <= 1'b0;
        repeat (6) @(posedge clk);
        chk("inv low", 32'h88, func);
        bus(1, 8'h64, 0);
        $display("direct input done");
    endtask

    task automatic t_dead();
        bus(1, 8'h40, 32'hFF00_0003);
        bus(0, 8'h40, 0); chk("clamp", 32'hFA00_0003, rq);
        bus(1, 8'h40, 32'h0300_0003);
        want[0] <= 1'b1;
        repeat (40) @(posedge clk);
        chk("dead early", 0, func);
        repeat (30) @(posedge clk);
        chk("dead late", 32'h8, func);
        want[0] <= 1'b0;
        bus(1, 8'h40, 32'h0002_0003);
        repeat (4) @(posedge clk);
        want[0] <= 1'b1;
        repeat (5) @(posedge clk);
        chk("shot on", 32'h8, func);
        repeat (10) @(posedge clk);
        chk("shot off", 0, func);
        want[0] <= 1'b0;
        $display("dead-time and one-shot done");
    endtask

    task automatic t_vin();
        bus(1, 8'h8C, 32'h0000_0509);
        sig[5] <= 1'b1;
        repeat (5) @(posedge clk);
        chk("virtual", 32'h200, func);
        bus(0, 8'h00, 0); chk("status", 32'h0000_2000, rq);
        sig[5] <= 1'b0;
        $display("virtual input done");
    endtask

    task automatic t_outs();
        for (int i = 0; i < 32; i++) begin
            bus(1, 8'hD4, 32'h0000_0604 | (i[2:0] << 16));
            bus(1, 8'hE4, 32'h0000_0604 | (i[2:0] << 16));
            sig[4] <= i[3];
            sig[6] <= i[4];
            e = i[2] ? ((i[3] ^ i[0]) | (i[4] ^ i[1])) : ((i[3] ^ i[0]) & (i[4] ^ i[1]));
            repeat (5) @(posedge clk);
            chk("dout", {31'h0, e}, {31'h0, dout[5]});
            chk("user", {31'h0, e}, {31'h0, usr[1]});
        end
        bus(1, 8'hD4, 32'h0204_0004);
        sig <= 32'h10;
        repeat (5) @(posedge clk);
        sig <= 32'h0;
        repeat (15) @(posedge clk);
        chk("delay hold", 1, {31'h0, dout[5]});
        repeat (45) @(posedge clk);
        chk("delay off", 0, {31'h0, dout[5]});
        $display("outputs done");
    endtask

    task automatic test_done();
        $display("checks %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    always @(posedge clk) begin
        cyc++;
        if (cyc == 5000) begin
            mismatches++;
            test_done();
        end
    end

    initial begin
        repeat (16) @(posedge clk);
        arst_n <= 1'b1;
        @(posedge clk);
        t_defaults();
        t_din();
        t_dead();
        t_vin();
        t_outs();
        test_done();
    end
endmodule // io_signal_mapping_tb
